// File: tb/cbs_boot_select_tb_top.sv
// Testbench of the boot source selector
`timescale 1ns/100ps
`default_nettype none
module cbs_boot_select_tb_top;
  // ****************
  // Signals
  // ****************
  logic sys_clk, rst, card_is_mmc, step_ok, step_fail, card_dat0_in, i2c_read, ack_en;
  cbs_pkg::cbs_fuse_t fuse;
  logic [1:0] boot_mode_pins, spi_cs_index;
  logic [7:0] ext_csd_179, i2c_select_byte;
  logic card_clk, card_cmd_out, card_cmd_oe_n, card_wide_bus, acmd41_fast_boot;
  logic [2:0] card_host_onehot, boot_partition;
  logic card_low_voltage, emmc_boot_mode, card_ready, spi_boot, spi_three_byte, i2c_boot;
  logic i2c_tick, direct_boot, security_nonsecure, config_invalid, boot_fail;
  int n_errors = 0;
  int checked = 0;
  cbs_boot_select #(.ACK_WAIT_CYC(20)) dut (.sys_clk, .rst, .fuse, .boot_mode_pins,
    .card_is_mmc, .step_ok, .step_fail, .ext_csd_179, .card_dat0_in, .i2c_read, .card_clk,
    .card_cmd_out, .card_cmd_oe_n, .card_wide_bus, .acmd41_fast_boot, .card_host_onehot,
    .card_low_voltage, .emmc_boot_mode, .boot_partition, .card_ready, .spi_boot,
    .spi_three_byte, .spi_cs_index, .i2c_boot, .i2c_select_byte, .i2c_tick, .direct_boot,
    .security_nonsecure, .config_invalid, .boot_fail);
  cbs_card_model card (.sys_clk, .rst, .card_cmd_oe_n, .ack_en, .card_dat0_in);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // ****************
  // Tasks
  // ****************
  task automatic give_verdict();
    $display("Totals: %0d checks, %0d mismatches", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic start(input logic [10:0] f, input logic [1:0] p);
    rst = 1'b1;
    fuse = f;
    boot_mode_pins = p;
    repeat (10) @(posedge sys_clk);
    #1 rst = 1'b0;
  endtask
  task automatic pulses(input logic [3:0] seq, input int n);
    for (int i = 0; i < n; i++) begin
      step_ok = seq[i];
      step_fail = !seq[i];
      w(1);
    end
    step_ok = 1'b0;
    step_fail = 1'b0;
  endtask
  // Length of one high phase of the card clock
  task automatic hi_len(output int n);
    int i;
    n = 0;
    for (i = 0; i < 2000 && card_clk !== 1'b0; i++) w(1);
    for (i = 0; i < 2000 && card_clk !== 1'b1; i++) w(1);
    while (card_clk === 1'b1 && n < 2000) begin
      w(1);
      n++;
    end
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    int h, n;
    rst = 1'b1;
    fuse = '0;
    boot_mode_pins = 2'h0;
    {card_is_mmc, step_ok, step_fail, i2c_read, ack_en} = 5'h00;
    ext_csd_179 = 8'h00;
    start(11'h000, 2'h2);
    w(4);
    chk("direct_boot", 1, direct_boot);
    chk("security_nonsecure", 1, security_nonsecure);
    start(11'h001, 2'h2);
    w(4);
    chk("direct_boot blown", 0, direct_boot);
    chk("invalid ctl", 1, config_invalid);
    start(11'h680, 2'h0);
    w(4);
    chk("invalid type", 1, config_invalid);
    start(11'h618, 2'h0);
    w(4);
    chk("invalid host", 1, config_invalid);
    chk("invalid host onehot", 3'h0, card_host_onehot);
    $display("test selection done");
    for (h = 0; h < 2; h++) begin
      start(11'h780 | (11'(h) << 1), 2'h0);
      w(4);
      chk("spi_boot", 1, spi_boot);
      chk("spi_three_byte", h, spi_three_byte);
      chk("spi_cs_index", 2'h1, spi_cs_index);
      chk("i2c_boot", 0, i2c_boot);
    end
    i2c_read = 1'b1;
    start(11'h700, 2'h0);
    w(4);
    chk("i2c_boot", 1, i2c_boot);
    chk("i2c_select_byte", 8'ha1, i2c_select_byte);
    for (h = 0; h < 2000 && i2c_tick !== 1'b1; h++) w(1);
    for (n = 1; n < 2000; n++) begin
      w(1);
      if (i2c_tick === 1'b1) break;
    end
    chk("i2c tick period", 625, n);
    $display("test serial done");
    for (h = 0; h < 3; h++) begin
      start({2'h3, 2'h0, 1'b0, h[0], h[1:0], 3'h0}, 2'h0);
      w(3);
      chk("card_host_onehot", 3'h1 << h, card_host_onehot);
      chk("acmd41_fast_boot", h[0], acmd41_fast_boot);
      chk("card_wide_bus", 0, card_wide_bus);
      hi_len(n);
      chk("ident clk high", 400, n);
      pulses({h == 2, 3'b110}, 4);
      w(3);
      chk("card_low_voltage", 1, card_low_voltage);
      chk("card_ready", 1, card_ready);
      chk("sd partition", h == 2, boot_partition);
      hi_len(n);
      chk("run clk high", 7, n);
      chk("card_wide_bus run", 0, card_wide_bus);
    end
    $display("test sd done");
    card_is_mmc = 1'b1;
    ext_csd_179 = 8'h10;
    ack_en = 1'b1;
    start(11'h604, 2'h0);
    w(3);
    chk("card_cmd_oe_n", 0, card_cmd_oe_n);
    chk("card_cmd_out", 0, card_cmd_out);
    w(5);
    pulses(4'b0011, 2);
    w(4);
    chk("card_ready ack", 1, card_ready);
    chk("emmc_boot_mode", 1, emmc_boot_mode);
    chk("emmc partition", 3'h2, boot_partition);
    ack_en = 1'b0;
    ext_csd_179 = 8'h00;
    start(11'h604, 2'h0);
    w(30);
    pulses(4'b0001, 2);
    w(4);
    chk("card_ready no ack", 1, card_ready);
    chk("emmc_boot_mode no ack", 0, emmc_boot_mode);
    chk("user partition", 3'h0, boot_partition);
    start(11'h600, 2'h0);
    w(3);
    pulses(4'b0000, 1);
    w(3);
    chk("mmc boot_fail", 1, boot_fail);
    chk("mmc card_low_voltage", 0, card_low_voltage);
    $display("test mmc done");
    give_verdict();
  end
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire

// File: tb/cbs_card_model.sv
// Card model that answers the boot acknowledge
`timescale 1ns/100ps
`default_nettype none
module cbs_card_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic card_cmd_oe_n,
  input wire logic ack_en,
  output logic card_dat0_in
);
  // ****************
  // Acknowledge timing
  // ****************
  logic [3:0] low_cnt_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_cnt_ff <= 4'h0;
    end else if (card_cmd_oe_n) begin
      low_cnt_ff <= 4'h0;
    end else if (low_cnt_ff != 4'hf) begin
      low_cnt_ff <= low_cnt_ff + 4'h1;
    end
  end
  // Ack low on data line zero, else pulled up
  assign card_dat0_in = !(ack_en && (low_cnt_ff >= 4'h5));
endmodule
`default_nettype wire

// File: verilog/cbs_boot_map.svh
// Constants of the boot source selector
`ifndef CBS_BOOT_MAP_SVH
`define CBS_BOOT_MAP_SVH
`define CBS_SYS_CLK_HZ 250000000
`define CBS_CTL_EXT 2'h3
`define CBS_TYPE_CARD 2'h0
`define CBS_TYPE_RSVD 2'h1
`define CBS_TYPE_I2C 2'h2
`define CBS_TYPE_SPI 2'h3
`define CBS_BOOT_MODE_PINS_DIRECT 2'h2
`define CBS_HOST_1 2'h0
`define CBS_HOST_2 2'h1
`define CBS_HOST_3 2'h2
`define CBS_ACMD41_FAST_BIT 29
`define CBS_EXT_CSD_PART_BYTE 179
`define CBS_PART_LSB 3
`define CBS_PART_MSB 5
`define CBS_PART_USER 3'h0
`define CBS_PART_SD_BOOT 3'h1
`define CBS_I2C_DEV_ID 4'ha
`define CBS_I2C_CHIP_EN 3'h0
`define CBS_SPI_CS_INDEX 2'h1
`define CBS_ID_CLK_HZ 312500
`define CBS_RUN_CLK_HZ 16666000
`define CBS_I2C_CLK_HZ 400000
`define CBS_ACK_WAIT_MS 50
`define CBS_ID_CYC ((`CBS_SYS_CLK_HZ + `CBS_ID_CLK_HZ - 1) / `CBS_ID_CLK_HZ)
`define CBS_RUN_CYC ((`CBS_SYS_CLK_HZ + (`CBS_RUN_CLK_HZ / 2)) / `CBS_RUN_CLK_HZ)
`define CBS_I2C_CYC ((`CBS_SYS_CLK_HZ + `CBS_I2C_CLK_HZ - 1) / `CBS_I2C_CLK_HZ)
`define CBS_ACK_CYC (`CBS_ACK_WAIT_MS * (`CBS_SYS_CLK_HZ / 1000))
`endif

// File: verilog/cbs_boot_select.sv
// Boot source selection and card bring-up sequencer
// Notes on behaviour
// [RL1] Card boot uses one data line only
// [RL2] Card boot needs controller select 11
// [RL3] Card type 00 valid; 01,10,11 not cards
// [RL4] Spare fuse bit 0 drives ACMD41 bit 29
// [RL5] Host select 00/01/10 picks host 1/2/3
// [RL6] Identification runs card clock at 312.5 kHz
// [RL7] After identification card clock is 16.666 MHz
// [RL8] MMC: high voltage check, any capacity accepted
// [RL9] SD: high voltage first, low on failure
// [RL10] eMMC partition from byte 179, else user
// [RL11] Ack feature holds command line low
// [RL12] Card returns acknowledge on data line zero
// [RL13] Wait 50 ms for acknowledge, else MMC
// [RL14] SD partition failure means plain SD card
// [RL15] SD data bus never widened past one line
// [RL16] Serial ROM boot needs controller select 11
// [RL17] SPI width bit: 0 two-byte, 1 three-byte
// [RL18] Type 10 selects I2C, 11 selects SPI
// [RL19] SPI ROM sits on chip select one
// [RL20] I2C select byte is 1010 000 plus RW
// [RL21] I2C clock kept at or below 400 kHz
// [RL22] Pins 10 and fuse unblown: direct boot
// [RL23] Direct boot forces security controller non-secure
// [RL24] Reserved or unused encodings abandon the source
`timescale 1ns/100ps
`include "cbs_boot_map.svh"
`default_nettype none
module cbs_boot_select #(
  parameter int unsigned ACK_WAIT_CYC = `CBS_ACK_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire cbs_pkg::cbs_fuse_t fuse,
  input wire logic [1:0] boot_mode_pins,
  input wire logic card_is_mmc,
  input wire logic step_ok,
  input wire logic step_fail,
  input wire logic [7:0] ext_csd_179,
  input wire logic card_dat0_in,
  input wire logic i2c_read,
  output logic card_clk,
  output logic card_cmd_out,
  output logic card_cmd_oe_n,
  output logic card_wide_bus,
  output logic acmd41_fast_boot,
  output logic [2:0] card_host_onehot,
  output logic card_low_voltage,
  output logic emmc_boot_mode,
  output logic [2:0] boot_partition,
  output logic card_ready,
  output logic spi_boot,
  output logic spi_three_byte,
  output logic [1:0] spi_cs_index,
  output logic i2c_boot,
  output logic [7:0] i2c_select_byte,
  output logic i2c_tick,
  output logic direct_boot,
  output logic security_nonsecure,
  output logic config_invalid,
  output logic boot_fail
);
  localparam logic [9:0] ID_CYC = 10'(`CBS_ID_CYC);
  localparam logic [9:0] RUN_CYC = 10'(`CBS_RUN_CYC);
  localparam logic [9:0] I2C_CYC = 10'(`CBS_I2C_CYC);
  localparam logic [23:0] ACK_LAST = 24'(ACK_WAIT_CYC - 1);

  // ****************************************
  // Sequencer
  // ****************************************
  cbs_pkg::cbs_state_t state_ff, nxt_state;
  logic [23:0] ack_cnt_ff, nxt_ack_cnt;
  logic [2:0] part_ff, nxt_part;
  logic low_v_ff, nxt_low_v;
  logic ack_mode_ff, nxt_ack_mode;
  logic card_ok, serial_ok;

  always_comb begin
    nxt_state = state_ff;
    nxt_ack_cnt = ack_cnt_ff;
    nxt_part = part_ff;
    nxt_low_v = low_v_ff;
    nxt_ack_mode = ack_mode_ff;
    card_ok = (fuse.boot_memory_controller_select == `CBS_CTL_EXT) &&
              (fuse.card_host_select != 2'h3); // [RL2] [RL24]
    serial_ok = (fuse.boot_memory_controller_select == `CBS_CTL_EXT); // [RL16]
    unique case (state_ff)
      cbs_pkg::S_IDLE: nxt_state = cbs_pkg::S_DECODE;
      cbs_pkg::S_DECODE: begin
        nxt_ack_cnt = 24'h0;
        nxt_part = `CBS_PART_USER;
        nxt_low_v = 1'b0;
        nxt_ack_mode = 1'b0;
        if ((boot_mode_pins == `CBS_BOOT_MODE_PINS_DIRECT) && !fuse.direct_boot_disable_fuse) begin
          nxt_state = cbs_pkg::S_DIRECT; // [RL22]
        end else if (fuse.boot_memory_type_select == `CBS_TYPE_CARD && card_ok) begin
          nxt_state = (card_is_mmc && fuse.ecc_strength_fuse) ? cbs_pkg::S_ACK
                                                              : cbs_pkg::S_VHI; // [RL3]
        end else if (fuse.boot_memory_type_select == `CBS_TYPE_I2C && serial_ok) begin
          nxt_state = cbs_pkg::S_I2C; // [RL18]
        end else if (fuse.boot_memory_type_select == `CBS_TYPE_SPI && serial_ok) begin
          nxt_state = cbs_pkg::S_SPI; // [RL18]
        end else begin
          nxt_state = cbs_pkg::S_INVALID; // [RL24]
        end
      end
      cbs_pkg::S_ACK: begin
        if (!card_dat0_in) begin
          nxt_ack_mode = 1'b1; // [RL12] [RL13]
          nxt_state = cbs_pkg::S_VHI;
        end else if (ack_cnt_ff == ACK_LAST) begin
          nxt_state = cbs_pkg::S_VHI; // [RL13]
        end else begin
          nxt_ack_cnt = ack_cnt_ff + 24'h1;
        end
      end
      cbs_pkg::S_VHI: begin
        if (step_ok) begin
          nxt_state = cbs_pkg::S_CAP;
        end else if (step_fail) begin
          nxt_state = card_is_mmc ? cbs_pkg::S_FAIL : cbs_pkg::S_VLO; // [RL8] [RL9]
          nxt_low_v = !card_is_mmc; // [RL9]
        end
      end
      cbs_pkg::S_VLO: begin
        if (step_ok) begin
          nxt_state = cbs_pkg::S_CAP;
        end else if (step_fail) begin
          nxt_state = cbs_pkg::S_FAIL;
        end
      end
      cbs_pkg::S_CAP: begin
        if (step_ok || step_fail) begin
          nxt_state = cbs_pkg::S_PART; // [RL8]
        end
      end
      cbs_pkg::S_PART: begin
        if (card_is_mmc) begin
          nxt_part = ext_csd_179[`CBS_PART_MSB:`CBS_PART_LSB]; // [RL10]
          nxt_state = cbs_pkg::S_CARD_RUN;
        end else if (step_ok) begin
          nxt_part = `CBS_PART_SD_BOOT;
          nxt_state = cbs_pkg::S_CARD_RUN;
        end else if (step_fail) begin
          nxt_part = `CBS_PART_USER; // [RL14]
          nxt_state = cbs_pkg::S_CARD_RUN;
        end
      end
      cbs_pkg::S_CARD_RUN, cbs_pkg::S_SPI, cbs_pkg::S_I2C, cbs_pkg::S_DIRECT,
      cbs_pkg::S_INVALID, cbs_pkg::S_FAIL: begin
        nxt_state = state_ff;
      end
      default: nxt_state = cbs_pkg::S_FAIL;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= cbs_pkg::S_IDLE;
      ack_cnt_ff <= 24'h0;
      part_ff <= 3'h0;
      low_v_ff <= 1'b0;
      ack_mode_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ack_cnt_ff <= nxt_ack_cnt;
      part_ff <= nxt_part;
      low_v_ff <= nxt_low_v;
      ack_mode_ff <= nxt_ack_mode;
    end
  end

  // ****************************************
  // Clock divider
  // ****************************************
  logic [9:0] div_cnt_ff, nxt_div_cnt, div_len;
  logic card_clk_ff, nxt_card_clk, i2c_tick_ff, nxt_i2c_tick;
  logic id_phase, card_phase;

  always_comb begin
    id_phase = (state_ff == cbs_pkg::S_VHI) || (state_ff == cbs_pkg::S_VLO) ||
               (state_ff == cbs_pkg::S_CAP) || (state_ff == cbs_pkg::S_PART) ||
               (state_ff == cbs_pkg::S_ACK);
    card_phase = id_phase || (state_ff == cbs_pkg::S_CARD_RUN);
    if (state_ff == cbs_pkg::S_CARD_RUN) begin
      div_len = RUN_CYC; // [RL7]
    end else if (state_ff == cbs_pkg::S_I2C) begin
      div_len = I2C_CYC; // [RL21]
    end else begin
      div_len = ID_CYC; // [RL6]
    end
    nxt_div_cnt = (div_cnt_ff >= div_len - 10'h1) ? 10'h0 : div_cnt_ff + 10'h1;
    nxt_card_clk = card_phase && (nxt_div_cnt < (div_len >> 1));
    nxt_i2c_tick = (state_ff == cbs_pkg::S_I2C) && (nxt_div_cnt == 10'h0);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_cnt_ff <= 10'h0;
      card_clk_ff <= 1'b0;
      i2c_tick_ff <= 1'b0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      card_clk_ff <= nxt_card_clk;
      i2c_tick_ff <= nxt_i2c_tick;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  logic [2:0] host_ff, nxt_host;
  logic cmd_oe_n_ff, nxt_cmd_oe_n;
  logic flags_card_ff, flags_spi_ff, flags_i2c_ff, flags_dir_ff, flags_inv_ff;
  logic flags_fail_ff, fast_ff, three_ff, emmc_ff;
  logic nxt_card, nxt_spi, nxt_i2c, nxt_dir, nxt_inv, nxt_fail, nxt_fast, nxt_three;
  logic nxt_emmc;
  logic [7:0] sel_byte_ff, nxt_sel_byte;
  logic [1:0] spi_cs_ff, nxt_spi_cs;

  always_comb begin
    nxt_host = 3'h0;
    if (card_phase) begin
      unique case (fuse.card_host_select)
        `CBS_HOST_1: nxt_host = 3'h1; // [RL5]
        `CBS_HOST_2: nxt_host = 3'h2; // [RL5]
        `CBS_HOST_3: nxt_host = 3'h4; // [RL5]
        default: nxt_host = 3'h0;
      endcase
    end
    nxt_cmd_oe_n = !(nxt_state == cbs_pkg::S_ACK); // [RL11]
    nxt_card = (state_ff == cbs_pkg::S_CARD_RUN);
    nxt_spi = (state_ff == cbs_pkg::S_SPI);
    nxt_i2c = (state_ff == cbs_pkg::S_I2C);
    nxt_dir = (state_ff == cbs_pkg::S_DIRECT);
    nxt_inv = (state_ff == cbs_pkg::S_INVALID);
    nxt_fail = (state_ff == cbs_pkg::S_FAIL);
    nxt_fast = card_phase && !card_is_mmc && fuse.spare_size_fuse[0]; // [RL4]
    nxt_three = nxt_spi && fuse.bus_width_select; // [RL17]
    nxt_emmc = nxt_card && ack_mode_ff; // [RL13]
    nxt_sel_byte = nxt_i2c ? {`CBS_I2C_DEV_ID, `CBS_I2C_CHIP_EN, i2c_read} : 8'h00; // [RL20]
    nxt_spi_cs = nxt_spi ? `CBS_SPI_CS_INDEX : 2'h0; // [RL19]
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      host_ff <= 3'h0;
      cmd_oe_n_ff <= 1'b1;
      flags_card_ff <= 1'b0;
      flags_spi_ff <= 1'b0;
      flags_i2c_ff <= 1'b0;
      flags_dir_ff <= 1'b0;
      flags_inv_ff <= 1'b0;
      flags_fail_ff <= 1'b0;
      fast_ff <= 1'b0;
      three_ff <= 1'b0;
      emmc_ff <= 1'b0;
      sel_byte_ff <= 8'h00;
      spi_cs_ff <= 2'h0;
    end else begin
      host_ff <= nxt_host;
      cmd_oe_n_ff <= nxt_cmd_oe_n;
      flags_card_ff <= nxt_card;
      flags_spi_ff <= nxt_spi;
      flags_i2c_ff <= nxt_i2c;
      flags_dir_ff <= nxt_dir;
      flags_inv_ff <= nxt_inv;
      flags_fail_ff <= nxt_fail;
      fast_ff <= nxt_fast;
      three_ff <= nxt_three;
      emmc_ff <= nxt_emmc;
      sel_byte_ff <= nxt_sel_byte;
      spi_cs_ff <= nxt_spi_cs;
    end
  end

  assign card_clk = card_clk_ff;
  assign card_cmd_out = 1'b0;
  assign card_cmd_oe_n = cmd_oe_n_ff;
  assign card_wide_bus = 1'b0; // [RL1] [RL15]
  assign acmd41_fast_boot = fast_ff;
  assign card_host_onehot = host_ff;
  assign card_low_voltage = low_v_ff;
  assign emmc_boot_mode = emmc_ff;
  assign boot_partition = part_ff;
  assign card_ready = flags_card_ff;
  assign spi_boot = flags_spi_ff;
  assign spi_three_byte = three_ff;
  assign spi_cs_index = spi_cs_ff; // [RL19]
  assign i2c_boot = flags_i2c_ff;
  assign i2c_select_byte = sel_byte_ff;
  assign i2c_tick = i2c_tick_ff;
  assign direct_boot = flags_dir_ff;
  assign security_nonsecure = flags_dir_ff; // [RL23]
  assign config_invalid = flags_inv_ff;
  assign boot_fail = flags_fail_ff;

  // ****************************************
  // Assertions
  // ****************************************
  a_direct_nonsec: assert property (@(posedge sys_clk) disable iff (rst) // [RL23]
    state_ff == cbs_pkg::S_DIRECT |=> direct_boot && security_nonsecure)
    else $error("direct boot without non-secure state");
  a_rsvd_type: assert property (@(posedge sys_clk) disable iff (rst) // [RL24]
    state_ff == cbs_pkg::S_DECODE && fuse.boot_memory_type_select == `CBS_TYPE_RSVD &&
    !(boot_mode_pins == `CBS_BOOT_MODE_PINS_DIRECT && !fuse.direct_boot_disable_fuse)
    |=> ##1 config_invalid)
    else $error("reserved type not rejected");
  a_ctl_gate: assert property (@(posedge sys_clk) disable iff (rst) // [RL2]
    state_ff == cbs_pkg::S_DECODE && fuse.boot_memory_controller_select != `CBS_CTL_EXT
    |=> state_ff inside {cbs_pkg::S_DIRECT, cbs_pkg::S_INVALID})
    else $error("boot source chosen without select 11");
  a_cmd_low_ack: assert property (@(posedge sys_clk) disable iff (rst) // [RL11]
    state_ff == cbs_pkg::S_ACK |-> !card_cmd_oe_n)
    else $error("command line released during ack wait");
  a_ack_bound: assert property (@(posedge sys_clk) disable iff (rst) // [RL13]
    state_ff == cbs_pkg::S_ACK |-> ack_cnt_ff <= ACK_LAST)
    else $error("ack wait overran");
  a_sd_low_v: assert property (@(posedge sys_clk) disable iff (rst) // [RL9]
    state_ff == cbs_pkg::S_VHI && step_fail && !step_ok && !card_is_mmc
    |=> state_ff == cbs_pkg::S_VLO && card_low_voltage)
    else $error("no low voltage retry");
  a_run_fast: assert property (@(posedge sys_clk) disable iff (rst) // [RL7]
    state_ff == cbs_pkg::S_CARD_RUN && $past(state_ff) == cbs_pkg::S_CARD_RUN
    |-> div_cnt_ff < RUN_CYC)
    else $error("run clock not fast");
  a_id_slow: assert property (@(posedge sys_clk) disable iff (rst) // [RL6]
    id_phase && $rose(card_clk_ff) && $past(id_phase) |-> (card_clk_ff || !id_phase)[*8])
    else $error("identification clock too fast");
  a_i2c_byte: assert property (@(posedge sys_clk) disable iff (rst) // [RL20]
    i2c_boot |-> i2c_select_byte[7:1] == 7'h50)
    else $error("bad i2c select byte");
  a_one_line: assert property (@(posedge sys_clk) disable iff (rst) // [RL15]
    card_ready |-> !card_wide_bus)
    else $error("bus widened");
  c_card_run: cover property (@(posedge sys_clk) disable iff (rst) card_ready);
  c_emmc_ack: cover property (@(posedge sys_clk) disable iff (rst) emmc_boot_mode);
  c_spi_boot: cover property (@(posedge sys_clk) disable iff (rst) spi_boot && spi_three_byte);
  c_direct: cover property (@(posedge sys_clk) disable iff (rst) direct_boot);
endmodule
`default_nettype wire

// File: verilog/cbs_pkg.sv
// Types of the boot source selector
package cbs_pkg;
  typedef struct packed {
    logic [1:0] boot_memory_controller_select;
    logic [1:0] boot_memory_type_select;
    logic [1:0] spare_size_fuse;
    logic [1:0] card_host_select;
    logic ecc_strength_fuse;
    logic bus_width_select;
    logic direct_boot_disable_fuse;
  } cbs_fuse_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_DECODE = 4'h1,
    S_ACK = 4'h2,
    S_VHI = 4'h3,
    S_VLO = 4'h4,
    S_CAP = 4'h5,
    S_PART = 4'h6,
    S_CARD_RUN = 4'h7,
    S_SPI = 4'h8,
    S_I2C = 4'h9,
    S_DIRECT = 4'ha,
    S_INVALID = 4'hb,
    S_FAIL = 4'hc
  } cbs_state_t;
endpackage
